// ### design/irq_regs_pkg.sv
package irq_regs_pkg;

	// ==========================================================
	// Register map (word index equals byte address here)
	// ==========================================================
	localparam int ADDR_W = 4;
	localparam logic [3:0] FRAMER_IRQ_ENABLE_ADDR = 4'h5; // Enable register
	localparam logic [3:0] DATA_LINK_STATUS_ONE_ADDR = 4'h6; // Link status, read clears
	localparam logic [3:0] FRAMER_IRQ_STATUS_ADDR = 4'h7; // Framer status, read clears
	localparam logic [3:0] DATA_LINK_IRQ_ENABLE_ADDR = 4'h8; // Link status mask

	// ==========================================================
	// Field positions
	// ==========================================================
	localparam int FRAME_LOSS_BIT = 3;
	localparam int MIMIC_BIT = 2;
	localparam int CRC4_BIT = 1;
	localparam int ALIGN_BIT = 0;
	localparam int MSG_KIND_BIT = 7;
	localparam int TX_BEGUN_BIT = 6;
	localparam int RX_BEGUN_BIT = 5;
	localparam int TX_DONE_BIT = 4;

	// ==========================================================
	// Reset values
	// ==========================================================
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;

	// Framer events: one-cycle pulses, except the frame_loss level
	typedef struct packed {
		logic frame_loss; // Out-of-frame defect level
		logic mimic_detect; // Mimic pattern seen
		logic crc4_error; // CRC-4 sub-multiframe error
		logic align_bit_error; // Alignment bit error(s)
	} framer_events_t;

	// Data link controller events
	typedef struct packed {
		logic tx_message_begun; // Transmit started
		logic rx_message_begun; // Receive started
		logic tx_message_done; // Transmit finished
		logic rx_message_kind_valid; // Kind below is fresh
		logic rx_message_kind; // 1 message-oriented, 0 bit-oriented
	} link_events_t;

	// Register bus request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

endpackage

// ### design/e1_framer_hdlc_irq_regs.sv
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps

// Functional notes
// - Loss-of-frame change irq, both edges
// - Frame mimic detection raises irq
// - CRC-4 error raises irq
// - Alignment bit error raises irq
// - Alignment error never forces realignment
// - Enable bits read-write, reset zero
// - Bit 7 shows last message kind
// - Bit 6 set on transmit start
// - Bit 5 set on receive start
// - Status flags clear on read, reset zero
// - Error status latched regardless of enable
module e1_framer_hdlc_irq_regs (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Register port
	input wire irq_regs_pkg::reg_req_t req_in,
	output logic [7:0] rdata_out,
	// Event sources, same clock domain
	input wire irq_regs_pkg::framer_events_t framer_in,
	input wire irq_regs_pkg::link_events_t link_in,
	// Interrupt and framer guard
	output logic irq_out,
	output logic force_realign_out
);
	import irq_regs_pkg::*;

	// ==========================================================
	// Registers
	// ==========================================================
	logic [7:0] enable_q; // Framer enables, low nibble used
	logic [7:0] link_enable_q; // Link enables, bits 6..4
	logic [3:0] framer_status_q; // Sticky framer flags
	logic [2:0] link_status_q; // Sticky link flags, bits 6..4
	logic msg_kind_q; // Last received message kind
	logic frame_loss_q; // Previous defect level
	logic [7:0] rdata_d; // Read data before the output register
	logic frame_loss_change; // Defect declared or cleared this cycle
	logic rd_fr; // Read of framer status
	logic rd_link; // Read of link status
	logic wr_fr; // Write to framer status, ones clear
	logic wr_link; // Write to link status, ones clear
	logic [3:0] framer_clear; // Framer flags to drop this cycle
	logic [2:0] link_clear; // Link flags to drop this cycle

	assign rd_fr = req_in.rd && (req_in.addr == FRAMER_IRQ_STATUS_ADDR);
	assign rd_link = req_in.rd && (req_in.addr == DATA_LINK_STATUS_ONE_ADDR);
	assign wr_fr = req_in.wr && (req_in.addr == FRAMER_IRQ_STATUS_ADDR);
	assign wr_link = req_in.wr && (req_in.addr == DATA_LINK_STATUS_ONE_ADDR);
	// A read drops every flag of its register; a write drops the ones written
	assign framer_clear = rd_fr ? 4'hF : (wr_fr ? req_in.wdata[3:0] : 4'h0);
	assign link_clear = rd_link ? 3'h7 : (wr_link ? req_in.wdata[6:4] : 3'h0);

	// ==========================================================
	// Enable registers
	// ==========================================================
	// Software writes; only defined bits are stored
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			enable_q <= ENABLE_RESET;
			link_enable_q <= ENABLE_RESET;
		end else if (req_in.wr) begin
			if (req_in.addr == FRAMER_IRQ_ENABLE_ADDR) begin
				enable_q <= {4'h0, req_in.wdata[3:0]};
			end
			if (req_in.addr == DATA_LINK_IRQ_ENABLE_ADDR) begin
				link_enable_q <= {1'b0, req_in.wdata[6:4], 4'h0};
			end
		end
	end

	// ==========================================================
	// Framer event capture
	// ==========================================================
	// Defect level edge detector catches declare and clear alike
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			frame_loss_q <= 1'b0;
		end else begin
			frame_loss_q <= framer_in.frame_loss;
		end
	end
	assign frame_loss_change = framer_in.frame_loss ^ frame_loss_q;

	// Set wins over a read or write clear so no event is lost
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			framer_status_q <= STATUS_RESET[3:0];
		end else begin
			framer_status_q <= (framer_status_q & ~framer_clear) | {
				frame_loss_change,
				framer_in.mimic_detect,
				framer_in.crc4_error,
				framer_in.align_bit_error};
		end
	end

	// Alignment errors are only reported; realign is never asked for here
	assign force_realign_out = 1'b0;

	// ==========================================================
	// Data link event capture
	// ==========================================================
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			link_status_q <= STATUS_RESET[6:4];
		end else begin
			link_status_q <= (link_status_q & ~link_clear) | {
				link_in.tx_message_begun,
				link_in.rx_message_begun,
				link_in.tx_message_done};
		end
	end

	// Kind holds until the next received message updates it
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			msg_kind_q <= 1'b0;
		end else if (link_in.rx_message_kind_valid) begin
			msg_kind_q <= link_in.rx_message_kind;
		end
	end

	// ==========================================================
	// Read data, one cycle after the strobe
	// ==========================================================
	always_comb begin
		rdata_d = 8'h00; // Unmapped reads return zero
		unique case (req_in.addr)
			FRAMER_IRQ_ENABLE_ADDR: rdata_d = enable_q;
			DATA_LINK_STATUS_ONE_ADDR: rdata_d = {msg_kind_q, link_status_q, 4'h0};
			FRAMER_IRQ_STATUS_ADDR: rdata_d = {4'h0, framer_status_q};
			DATA_LINK_IRQ_ENABLE_ADDR: rdata_d = link_enable_q;
			default: rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_out <= 8'h00;
		end else if (req_in.rd) begin
			rdata_out <= rdata_d;
		end else begin
			rdata_out <= 8'h00;
		end
	end

	// ==========================================================
	// Interrupt output
	// ==========================================================
	// Level output: drops once the flag is read away
	assign irq_out = |(framer_status_q & enable_q[3:0]) ||
		|(link_status_q & link_enable_q[6:4]);

	// ==========================================================
	// Checks
	// ==========================================================
	// Steps of a kind check: a fresh report, then a quiet read of the link status
	sequence kind_report_s;
		link_in.rx_message_kind_valid;
	endsequence

	sequence kind_read_s;
		rd_link && !link_in.rx_message_kind_valid;
	endsequence

	a_crc_sticky: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		framer_in.crc4_error |=> framer_status_q[CRC4_BIT])
		else $error("crc flag not set");
	a_align_sticky: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		framer_in.align_bit_error |=> framer_status_q[ALIGN_BIT])
		else $error("align flag not set");
	a_loss_edge: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$fell(framer_in.frame_loss) |=> framer_status_q[FRAME_LOSS_BIT])
		else $error("defect clear not flagged");
	a_mimic_sticky: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		framer_in.mimic_detect |=> framer_status_q[MIMIC_BIT])
		else $error("mimic flag not set");
	a_txbegin_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		link_in.tx_message_begun |=> link_status_q[2])
		else $error("tx begin flag not set");
	a_rxbegin_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		link_in.rx_message_begun |=> link_status_q[1])
		else $error("rx begin flag not set");
	a_txdone_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		link_in.tx_message_done |=> link_status_q[0])
		else $error("tx done flag not set");
	a_read_clears: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rd_link && !link_in.tx_message_begun |=> !link_status_q[2])
		else $error("read did not clear");
	a_enable_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		req_in.wr && req_in.addr == FRAMER_IRQ_ENABLE_ADDR
		|=> enable_q[3:0] == $past(req_in.wdata[3:0]))
		else $error("enable not stored");
	a_irq_level: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		enable_q[CRC4_BIT] && framer_in.crc4_error &&
		!(req_in.wr && req_in.addr == FRAMER_IRQ_ENABLE_ADDR) |=> irq_out)
		else $error("irq not raised");
	a_kind_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		kind_report_s ##1 kind_read_s
		|=> rdata_out[MSG_KIND_BIT] == $past(link_in.rx_message_kind, 2))
		else $error("kind wrong");
	a_no_realign: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		framer_in.align_bit_error |-> !force_realign_out)
		else $error("realign forced");

	// ==========================================================
	// Checks on clearing, holding and gating
	// ==========================================================
	// Rising defect is the other half of a change
	a_loss_rise: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(framer_in.frame_loss) |=> framer_status_q[FRAME_LOSS_BIT])
		else $error("defect declare not flagged");

	// An alignment error alone must not look like lost framing
	a_align_no_loss: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		framer_in.align_bit_error && !frame_loss_change && !framer_status_q[FRAME_LOSS_BIT]
		|=> !framer_status_q[FRAME_LOSS_BIT])
		else $error("alignment error flagged as loss");

	// Zero in every enable keeps the output quiet whatever is pending
	a_irq_disabled: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		enable_q[3:0] == 4'h0 && link_enable_q[6:4] == 3'h0 |-> !irq_out)
		else $error("irq while disabled");

	// Enable register reads back what was stored
	a_enable_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		req_in.rd && req_in.addr == FRAMER_IRQ_ENABLE_ADDR
		|=> rdata_out == {4'h0, $past(enable_q[3:0])})
		else $error("enable read wrong");

	// Read data stand only in the cycle after a read strobe
	a_rdata_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!req_in.rd |=> rdata_out == 8'h00)
		else $error("read data outside read");

	// Kind is replaced by a fresh report only
	a_kind_update: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		link_in.rx_message_kind_valid |=> msg_kind_q == $past(link_in.rx_message_kind))
		else $error("kind not taken");

	a_kind_holds: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!link_in.rx_message_kind_valid |=> $stable(msg_kind_q))
		else $error("kind changed without report");

	// Flags stay set until a read or a written one drops them
	a_framer_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!rd_fr && !wr_fr |=> (framer_status_q & $past(framer_status_q)) == $past(framer_status_q))
		else $error("framer flag lost");

	a_link_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!rd_link && !wr_link |=> (link_status_q & $past(link_status_q)) == $past(link_status_q))
		else $error("link flag lost");

	// Every framer flag, and the link receive-start and transmit-done flags, drops on a read unless its event repeats
	a_crc_read_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rd_fr && !framer_in.crc4_error |=> !framer_status_q[CRC4_BIT])
		else $error("crc flag survived read");

	a_mimic_read_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rd_fr && !framer_in.mimic_detect |=> !framer_status_q[MIMIC_BIT])
		else $error("mimic flag survived read");

	a_align_read_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rd_fr && !framer_in.align_bit_error |=> !framer_status_q[ALIGN_BIT])
		else $error("align flag survived read");

	a_loss_read_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rd_fr && !frame_loss_change |=> !framer_status_q[FRAME_LOSS_BIT])
		else $error("defect flag survived read");

	a_rxbegin_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rd_link && !link_in.rx_message_begun |=> !link_status_q[1])
		else $error("rx begin survived read");

	a_txdone_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rd_link && !link_in.tx_message_done |=> !link_status_q[0])
		else $error("tx done survived read");

	// Writing a one drops the CRC-4 or transmit-done flag unless its event repeats
	a_crc_write_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		wr_fr && req_in.wdata[CRC4_BIT] && !framer_in.crc4_error
		|=> !framer_status_q[CRC4_BIT])
		else $error("crc flag survived write");

	a_txdone_write_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		wr_link && req_in.wdata[TX_DONE_BIT] && !link_in.tx_message_done
		|=> !link_status_q[0])
		else $error("tx done survived write");

	// Link flags reach the output through their own enables
	a_link_irq: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		link_enable_q[TX_BEGUN_BIT] && link_in.tx_message_begun &&
		!(req_in.wr && req_in.addr == DATA_LINK_IRQ_ENABLE_ADDR) |=> irq_out)
		else $error("link irq not raised");

	a_irq_needs_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		irq_out |-> (|framer_status_q) || (|link_status_q))
		else $error("irq with no flag");

	a_link_enable_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		req_in.wr && req_in.addr == DATA_LINK_IRQ_ENABLE_ADDR
		|=> link_enable_q[6:4] == $past(req_in.wdata[6:4]))
		else $error("link enable not stored");

endmodule // e1_framer_hdlc_irq_regs

// ### verification/e1_framer_hdlc_irq_regs_bench.sv
`timescale 1ns/1ps
module e1_framer_hdlc_irq_regs_bench;
	import irq_regs_pkg::*;
	// ==========================================================
	// Ports of the block and bench state
	// ==========================================================
	logic clk_in = 1'b0; // 10 MHz clock
	logic rst_n_in = 1'b0; // Reset held low at start
	reg_req_t req_in = '0; // Register request, idle at start
	framer_events_t framer_in = '0; // Framer events, quiet at start
	link_events_t link_in = '0; // Link events, quiet at start
	logic [7:0] rdata_out;
	logic irq_out;
	logic force_realign_out;
	int n_fail = 0; // Mismatches
	int checked = 0; // Comparisons
	int m_en = 0; // Model: framer enables
	int m_len = 0; // Model: link enables
	int m_fst = 0; // Model: framer flags
	int m_lst = 0; // Model: link flags
	int m_kind = 0; // Model: last message kind
	int m_loss = 0; // Model: frame loss level, low like the detector

	// Half period of 50 ns
	always #50 clk_in = ~clk_in;

	e1_framer_hdlc_irq_regs dut (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req_in), .rdata_out(rdata_out),
		.framer_in(framer_in), .link_in(link_in), .irq_out(irq_out),
		.force_realign_out(force_realign_out));

	// ==========================================================
	// Comparison, verdict and model
	// ==========================================================
	task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic print_verdict();
		if (n_fail == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// Value a read should return, before this cycle's events land
	function automatic int rd_val(int a);
		case (a)
			FRAMER_IRQ_ENABLE_ADDR: return m_en;
			DATA_LINK_STATUS_ONE_ADDR: return (m_kind << MSG_KIND_BIT) | m_lst;
			FRAMER_IRQ_STATUS_ADDR: return m_fst;
			DATA_LINK_IRQ_ENABLE_ADDR: return m_len;
			default: return 0;
		endcase
	endfunction

	// One request with events beside it; every op lasts two cycles so
	// no signal is driven twice in one time step
	task automatic op(reg_req_t r, framer_events_t f, link_events_t l);
		int e;
		req_in <= r;
		framer_in <= f;
		link_in <= l;
		@(posedge clk_in);
		e = rd_val(r.addr);
		// Read or written ones clear first, same-cycle events still set (set wins)
		if (r.rd && r.addr == DATA_LINK_STATUS_ONE_ADDR) m_lst = 0;
		if (r.rd && r.addr == FRAMER_IRQ_STATUS_ADDR) m_fst = 0;
		if (r.wr && r.addr == DATA_LINK_STATUS_ONE_ADDR) m_lst &= ~int'(r.wdata);
		if (r.wr && r.addr == FRAMER_IRQ_STATUS_ADDR) m_fst &= ~int'(r.wdata);
		if (r.wr && r.addr == FRAMER_IRQ_ENABLE_ADDR) m_en = r.wdata & 8'h0F;
		if (r.wr && r.addr == DATA_LINK_IRQ_ENABLE_ADDR) m_len = r.wdata & 8'h70;
		if (f.frame_loss != m_loss) m_fst |= 8'h08;
		m_loss = f.frame_loss;
		m_fst |= f[2:0];
		m_lst |= {l[4:2], 4'h0};
		if (l.rx_message_kind_valid) m_kind = l.rx_message_kind;
		req_in <= '0;
		framer_in <= {f.frame_loss, 3'h0};
		link_in <= '0;
		@(negedge clk_in);
		check("read data", rdata_out, r.rd ? e[7:0] : 8'h00);
		check("irq", irq_out, 8'((m_fst & m_en) != 0 || (m_lst & m_len) != 0));
		check("realign", force_realign_out, 8'h00);
		@(posedge clk_in);
	endtask

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		reg_req_t r;
		int k;
		void'($urandom(76103));
		repeat (16) @(posedge clk_in);
		rst_n_in <= 1'b1;
		// Reset values of every place, unmapped ones read zero
		for (int a = 0; a < 16; a++) op('{4'(a), 8'h00, 1'b0, 1'b1}, '0, '0);
		// Ones everywhere: only defined enable fields keep them
		for (int a = 0; a < 16; a++) op('{4'(a), 8'hFF, 1'b1, 1'b0}, '0, '0);
		for (int a = 0; a < 16; a++) op('{4'(a), 8'h00, 1'b0, 1'b1}, '0, '0);
		// Long message: start seen by a read, framer enables written, then the end
		op('{DATA_LINK_STATUS_ONE_ADDR, 8'h00, 1'b0, 1'b1}, '0, 5'h10);
		op('{DATA_LINK_STATUS_ONE_ADDR, 8'h00, 1'b0, 1'b1}, '0, '0);
		op('{FRAMER_IRQ_ENABLE_ADDR, 8'h0F, 1'b1, 1'b0}, '0, '0);
		op('{DATA_LINK_STATUS_ONE_ADDR, 8'h00, 1'b0, 1'b1}, '0, 5'h04);
		// Random traffic with sparse events, reads often clash with them
		repeat (400) begin
			k = $urandom_range(2);
			r.addr = 4'($urandom);
			r.wdata = 8'($urandom);
			r.wr = (k == 1);
			r.rd = (k == 2);
			op(r, 4'($urandom & $urandom), 5'($urandom & $urandom));
		end
		print_verdict();
	end

	// Watchdog: about ten times the expected run
	initial begin
		#1000000;
		n_fail++;
		print_verdict();
	end
endmodule // e1_framer_hdlc_irq_regs_bench
